// *** hw/hsi_consts.svh ***
// Named constants of the host serial interface
`ifndef HSI_CONSTS_SVH
`define HSI_CONSTS_SVH
// Clock and time base
`define HSI_CLK_NS 10
`define HSI_CLK_MHZ 100
`define HSI_MS_US 1000
`define HSI_MS_PER_S 1000
`define HSI_INPUT_FILTER_ENABLE_BIT_NS 200
// Two-wire slave address, 8-bit form 0x10 write and 0x11 read
`define HSI_I2C_DEV_DEF 7'h08
// Clock-low limits in ms (100 kHz window 25..35, 400 kHz window 5..20)
`define HSI_TO100_MS 11'd25
`define HSI_TO400_MS 11'd5
`define HSI_MEXT_MS 11'd10
`define HSI_FROZEN_MS 11'd2000
`define HSI_MS_SAT 11'h7ff
// Four-wire frame lengths and flag patterns
`define HSI_SPI_LEN_PLAIN 5'd16
`define HSI_SPI_LEN_CRC 5'd24
`define HSI_SPI_CNT_SAT 5'h1f
`define HSI_SPI_ALL_ONES 16'hffff
`define HSI_SPI_BAD_CRC 8'haa
`define HSI_SPI_OSC_CRC 8'hff
`define HSI_SPI_STALE_CRC 8'h00
`define HSI_SPI_MIN_HOLD_S 18'd1
// Checksum generator x^8+x^2+x+1, start value zero
`define HSI_CRC_POLY 8'h07
`define HSI_CRC_INIT 8'h00
`endif

// *** hw/hsi_pkg.sv ***
// Types shared by the host serial interface files
package hsi_pkg;
   typedef enum logic [2:0] {
      I_IDLE = 3'b000,
      I_DEV  = 3'b001,
      I_REG  = 3'b010,
      I_WDAT = 3'b011,
      I_WCRC = 3'b100,
      I_RDAT = 3'b101,
      I_RCRC = 3'b110
   } hsi_i2c_st_e;

   // Register access toward the internal logic
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hsi_acc_s;

   // One four-wire frame without its checksum
   typedef struct packed {
      logic rw;
      logic [6:0] addr;
      logic [7:0] data;
   } hsi_spi_word_s;
endpackage : hsi_pkg

// *** hw/hsi_crc8.sv ***
// Bit-serial checksum over a data word, MSB first
`timescale 1ns/100ps
`default_nettype none
`include "hsi_consts.svh"
module hsi_crc8 import hsi_pkg::*; #(
   parameter int DW = 8
) (
   // Running value and data in
   input wire logic [7:0] crc_in,
   input wire logic [DW-1:0] data,
   // Updated value
   output logic [7:0] crc_out
);
   logic [7:0] stage [0:DW];

   generate
      if (DW < 1) begin : g_chk
         $error("hsi_crc8: DW must be at least 1");
      end
   endgenerate

   assign stage[0] = crc_in;

   // One shift stage per data bit, no final inversion
   generate
      for (genvar i = 0; i < DW; i++) begin : g_bit
         logic fb;
         assign fb = stage[i][7] ^ data[DW-1-i];
         assign stage[i+1] = {stage[i][6:0], 1'b0} ^ ({8{fb}} & `HSI_CRC_POLY);
      end
   endgenerate

   assign crc_out = stage[DW];
endmodule : hsi_crc8
`default_nettype wire

// *** hw/hsi_sync_input_filter_enable_bit.sv ***
// Two-flop synchronisers with optional delay-line input filter
`timescale 1ns/100ps
`default_nettype none
module hsi_sync_input_filter_enable_bit import hsi_pkg::*; #(
   parameter int W = 6,
   parameter int DLY = 20,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Raw pins and per-bit filter select
   input wire logic [W-1:0] din,
   input wire logic [W-1:0] input_filter_enable_bit_en,
   // Clean levels
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [DLY-1:0][W-1:0] line;
      logic [W-1:0] out;
   } hsi_sf_state_s;

   localparam hsi_sf_state_s SF_RST = '{s1: RST_VAL, s2: RST_VAL,
      line: {DLY{RST_VAL}}, out: RST_VAL};

   hsi_sf_state_s q;
   hsi_sf_state_s d;

   generate
      if (W < 1 || DLY < 2) begin : g_chk
         $error("hsi_sync_input_filter_enable_bit: W >= 1 and DLY >= 2 required");
      end
   endgenerate

   // A pure delay keeps every edge, so fast serial clocks survive the filter
   always_comb begin
      d = q;
      d.s1 = din;
      d.s2 = q.s1;
      d.line = {q.line[DLY-2:0], q.s2};
      d.out = (input_filter_enable_bit_en & q.line[DLY-1]) | (~input_filter_enable_bit_en & q.s2);
   end

   // State register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= SF_RST;
      end else begin
         q <= d;
      end
   end

   assign dout = q.out;
endmodule : hsi_sync_input_filter_enable_bit
`default_nettype wire

// *** hw/hsi_top.sv ***
// Host serial interface: two-wire slave and four-wire mode-0 slave
`timescale 1ns/100ps
`default_nettype none
`include "hsi_consts.svh"
// Notes on behaviour
// - Without programmed settings, start in two-wire mode at the fast rate.
// - Speed change applies on leaving config mode; two-wire switch is immediate.
// - Answer address 0x10 write, 0x11 read; address loadable by configuration.
// - Slow rate with timeouts: reset on long clock low or stretch.
// - Fast rate with timeouts: reset when clock low exceeds 5..20 ms.
// - Always reset two-wire logic if clock stays low over 2 s.
// - Register address increments after every data byte in block transfers.
// - First write checksum covers address, register, data; later ones data only.
// - Checksum is CRC-8, polynomial x^8+x^2+x+1, starting at zero.
// - Receiver NACKs a bad checksum; slave then returns to idle.
// - Read checksum starts at first start; restarts after each checksum byte, stop.
// - Four-wire slave uses clock polarity 0, phase 0.
// - Frames are 16 bits plain, 24 with checksum; wrong count flags error.
// - Checksum setting accepts only checksummed or only plain frames.
// - Bad four-wire checksum drops frame, next reply is 0xFFFF then 0xAA.
// - Oscillator not ready at frame start: reply 0xFFFF and 0xFF.
// - Chip-select falling edge wakes the oscillator; ready may take 50 us.
// - Oscillator stays on for idle time, at least 1 s in four-wire mode.
// - Chip select low with static clock for 2 s resets four-wire logic.
// - Four-wire setting from config mode applies only on reset or switch.
// - Input delay filter unless disabled; supply select applies on switch.
// - First byte is direction bit then 7-bit address; second byte data.
// - With checksum the third byte is CRC over the first two bytes.
// - Stale outgoing buffer replies 0xFFFF and checksum 0x00.
module hsi_top import hsi_pkg::*; #(
   parameter int MS_CYCLES = `HSI_MS_US * `HSI_CLK_MHZ,
   parameter int INPUT_FILTER_ENABLE_BIT_CYC = `HSI_INPUT_FILTER_ENABLE_BIT_NS / `HSI_CLK_NS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Configuration
   input wire logic cfg_otp_valid,
   input wire logic cfg_use_spi,
   input wire logic cfg_i2c_fast,
   input wire logic cfg_i2c_crc,
   input wire logic cfg_spi_crc,
   input wire logic cfg_timeout_en,
   input wire logic [7:0] cfg_i2c_addr,
   input wire logic cfg_i2c_addr_wr,
   input wire logic [7:0] cfg_idle_time,
   input wire logic config_update_mode,
   input wire logic input_filter_enable_bit,
   input wire logic output_supply_select_bit,
   // Subcommands
   input wire logic switch_to_two_wire_cmd,
   input wire logic switch_to_four_wire_cmd,
   // Two-wire pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Four-wire pins
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_mosi,
   output logic spi_miso,
   output logic spi_miso_oe,
   // Oscillator
   input wire logic osc_ready,
   output logic osc_wake,
   // Two-wire register access
   output hsi_acc_s reg_acc,
   input wire logic [7:0] acc_rdata,
   // Four-wire buffers
   output logic spi_rx_valid,
   output hsi_spi_word_s spi_rx_word,
   input wire logic spi_tx_load,
   input wire logic [15:0] spi_tx_word,
   // Status
   output logic spi_mode,
   output logic i2c_fast,
   output logic miso_supply_sel,
   output logic spi_len_err,
   output logic spi_crc_err,
   output logic i2c_timeout
);
   localparam int TW = (MS_CYCLES > 2) ? $clog2(MS_CYCLES) : 1;

   typedef struct packed {
      logic init;
      logic spi_mode;
      logic fast;
      logic supply;
      logic cfgm_p;
      logic [6:0] dev;
      logic [TW-1:0] tick_cnt;
      logic tick;
      hsi_i2c_st_e ist;
      logic [3:0] ibit;
      logic [7:0] ish;
      logic [7:0] icrc;
      logic [7:0] iaddr;
      logic [7:0] ihold;
      logic iack;
      logic ifetch;
      logic ird_pend;
      logic sda_oe;
      logic scl_p;
      logic sda_p;
      logic [10:0] low_ms;
      logic [10:0] mext_ms;
      logic i2c_to;
      hsi_acc_s acc;
      logic cs_p;
      logic sclk_p;
      logic s_crc;
      logic sabort;
      logic [4:0] scnt;
      logic [23:0] srx;
      logic [23:0] stx;
      logic miso;
      logic miso_oe;
      logic [15:0] sout;
      logic sout_err;
      logic sfresh;
      logic [10:0] sstat_ms;
      logic rx_valid;
      hsi_spi_word_s rx_word;
      logic len_err;
      logic crc_err;
      logic [17:0] hold_ms;
      logic wake;
   } hsi_top_state_s;

   localparam hsi_top_state_s ST_RST = '{dev: `HSI_I2C_DEV_DEF, ist: I_IDLE,
      scl_p: 1'b1, sda_p: 1'b1, cs_p: 1'b1, default: '0};

   hsi_top_state_s q;
   hsi_top_state_s d;
   logic [5:0] pins;
   logic scl_s, sda_s, cs_s, sclk_s, mosi_s, osc_s;
   logic start, stop, rise, fall, isend, to_hit;
   logic cs_fall, cs_rise, srise, sfall;
   logic [7:0] i_crc_dat, i_crc_nxt, s_crc_nxt;
   logic [15:0] s_crc_dat;
   logic [17:0] hold_ld;

   generate
      if (MS_CYCLES < 2 || INPUT_FILTER_ENABLE_BIT_CYC < 2) begin : g_chk
         $error("hsi_top: MS_CYCLES and INPUT_FILTER_ENABLE_BIT_CYC must be at least 2");
      end
   endgenerate

   // Pins cross into mclk here; only the four-wire inputs see the filter
   hsi_sync_input_filter_enable_bit #(.W(6), .DLY(INPUT_FILTER_ENABLE_BIT_CYC), .RST_VAL(6'h07)) u_sync (
      .mclk(mclk),
      .arst_n(arst_n),
      .din({osc_ready, spi_mosi, spi_sclk, spi_cs_n, sda_i, scl_i}),
      .input_filter_enable_bit_en({1'b0, {3{input_filter_enable_bit}}, 2'b00}),
      .dout(pins)
   );
   assign {osc_s, mosi_s, sclk_s, cs_s, sda_s, scl_s} = pins;

   // One checksum engine per link; the two-wire one also absorbs read data
   assign i_crc_dat = q.ird_pend ? acc_rdata : q.ish;
   hsi_crc8 #(.DW(8)) u_icrc (
      .crc_in(q.icrc),
      .data(i_crc_dat),
      .crc_out(i_crc_nxt)
   );
   assign s_crc_dat = cs_fall ? q.sout : q.srx[23:8];
   hsi_crc8 #(.DW(16)) u_scrc (
      .crc_in(`HSI_CRC_INIT),
      .data(s_crc_dat),
      .crc_out(s_crc_nxt)
   );

   // Line events on the synchronised levels
   assign start = scl_s & q.sda_p & ~sda_s;
   assign stop = scl_s & ~q.sda_p & sda_s;
   assign rise = scl_s & ~q.scl_p;
   assign fall = ~scl_s & q.scl_p;
   assign isend = (q.ist == I_RDAT) || (q.ist == I_RCRC);
   assign cs_fall = q.cs_p & ~cs_s;
   assign cs_rise = ~q.cs_p & cs_s;
   assign srise = ~cs_s & sclk_s & ~q.sclk_p;
   assign sfall = ~cs_s & ~sclk_s & q.sclk_p;
   assign to_hit = (q.low_ms > `HSI_FROZEN_MS) |
      (cfg_timeout_en & q.fast & (q.low_ms > `HSI_TO400_MS)) |
      (cfg_timeout_en & ~q.fast & ((q.low_ms > `HSI_TO100_MS) |
      (q.mext_ms > `HSI_MEXT_MS)));
   assign hold_ld = (cfg_idle_time == 8'h00) ?
      (`HSI_SPI_MIN_HOLD_S * 18'(`HSI_MS_PER_S)) :
      (18'(cfg_idle_time) * 18'(`HSI_MS_PER_S));

   always_comb begin
      d = q;
      d.acc.wr = 1'b0;
      d.acc.rd = 1'b0;
      d.rx_valid = 1'b0;
      d.len_err = 1'b0;
      d.crc_err = 1'b0;
      d.i2c_to = 1'b0;
      d.scl_p = scl_s;
      d.sda_p = sda_s;
      d.cs_p = cs_s;
      d.sclk_p = sclk_s;
      d.cfgm_p = config_update_mode;
      // Millisecond time base for every long count
      d.tick = (q.tick_cnt == TW'(MS_CYCLES - 1));
      d.tick_cnt = d.tick ? '0 : q.tick_cnt + 1'b1;

      // Settings are caught in the first cycle after reset release
      if (!q.init) begin
         d.init = 1'b1;
         d.spi_mode = cfg_otp_valid & cfg_use_spi;
         d.fast = ~cfg_otp_valid | cfg_i2c_fast;
         d.supply = output_supply_select_bit;
      end
      if (q.cfgm_p && !config_update_mode) begin
         d.fast = cfg_i2c_fast;
      end
      if (switch_to_two_wire_cmd) begin
         d.spi_mode = 1'b0;
         d.supply = output_supply_select_bit;
      end else if (switch_to_four_wire_cmd) begin
         d.spi_mode = 1'b1;
         d.supply = output_supply_select_bit;
      end
      if (cfg_i2c_addr_wr) begin
         d.dev = cfg_i2c_addr[7:1];
      end

      // Clock-low and in-transfer low counters for the timeouts
      if (scl_s) begin
         d.low_ms = '0;
      end else if (q.tick && q.low_ms != `HSI_MS_SAT) begin
         d.low_ms = q.low_ms + 1'b1;
      end
      if (q.ist == I_IDLE) begin
         d.mext_ms = '0;
      end else if (q.tick && !scl_s && q.mext_ms != `HSI_MS_SAT) begin
         d.mext_ms = q.mext_ms + 1'b1;
      end

      // Two-wire slave
      if (q.spi_mode) begin
         d.ist = I_IDLE;
         d.ibit = '0;
         d.iack = 1'b0;
         d.ird_pend = 1'b0;
      end else if (start) begin
         if (q.ist == I_IDLE) begin
            d.icrc = `HSI_CRC_INIT;
         end
         d.ist = I_DEV;
         d.ibit = '0;
         d.iack = 1'b0;
         d.ifetch = 1'b0;
      end else if (stop) begin
         d.ist = I_IDLE;
         d.icrc = `HSI_CRC_INIT;
         d.ibit = '0;
         d.iack = 1'b0;
      end else begin
         // Read data arrives in the cycle the strobe stands
         if (q.ird_pend) begin
            d.ird_pend = 1'b0;
            d.ish = acc_rdata;
            d.icrc = i_crc_nxt;
            d.iaddr = q.iaddr + 1'b1;
         end
         if (rise) begin
            if (q.ibit < 4'd8) begin
               d.ibit = q.ibit + 1'b1;
               if (!isend) begin
                  d.ish = {q.ish[6:0], sda_s};
               end
            end else if (q.ibit == 4'd9 && isend && sda_s) begin
               d.ist = I_IDLE;
            end
         end
         if (fall && q.ibit == 4'd8) begin
            d.ibit = 4'd9;
            d.iack = 1'b0;
            unique case (q.ist)
               I_DEV: begin
                  if (q.ish[7:1] == q.dev) begin
                     d.iack = 1'b1;
                     d.icrc = i_crc_nxt;
                     d.ist = q.ish[0] ? I_RDAT : I_REG;
                     d.ifetch = q.ish[0];
                  end else begin
                     d.ist = I_IDLE;
                  end
               end
               I_REG: begin
                  d.iack = 1'b1;
                  d.iaddr = q.ish;
                  d.icrc = i_crc_nxt;
                  d.ist = I_WDAT;
               end
               I_WDAT: begin
                  d.iack = 1'b1;
                  if (cfg_i2c_crc) begin
                     d.ihold = q.ish;
                     d.icrc = i_crc_nxt;
                     d.ist = I_WCRC;
                  end else begin
                     d.acc = '{wr: 1'b1, rd: 1'b0, addr: q.iaddr, wdata: q.ish};
                     d.iaddr = q.iaddr + 1'b1;
                  end
               end
               I_WCRC: begin
                  if (q.ish == q.icrc) begin
                     d.iack = 1'b1;
                     d.acc = '{wr: 1'b1, rd: 1'b0, addr: q.iaddr, wdata: q.ihold};
                     d.iaddr = q.iaddr + 1'b1;
                     d.icrc = `HSI_CRC_INIT;
                     d.ist = I_WDAT;
                  end else begin
                     d.ist = I_IDLE;
                  end
               end
               I_RDAT, I_RCRC, I_IDLE: begin
                  d.iack = 1'b0;
               end
               default: begin
                  d.ist = I_IDLE;
               end
            endcase
         end else if (fall && q.ibit == 4'd9) begin
            d.ibit = '0;
            d.iack = 1'b0;
            if (q.ifetch) begin
               d.ifetch = 1'b0;
               d.acc = '{wr: 1'b0, rd: 1'b1, addr: q.iaddr, wdata: 8'h00};
               d.ird_pend = 1'b1;
            end else if (q.ist == I_RDAT && cfg_i2c_crc) begin
               d.ist = I_RCRC;
               d.ish = q.icrc;
            end else if (isend) begin
               // Next read byte; after its checksum the sum starts over
               if (q.ist == I_RCRC) begin
                  d.icrc = `HSI_CRC_INIT;
                  d.ist = I_RDAT;
               end
               d.acc = '{wr: 1'b0, rd: 1'b1, addr: q.iaddr, wdata: 8'h00};
               d.ird_pend = 1'b1;
            end
         end else if (fall && isend && q.ibit != 4'd0 && q.ibit < 4'd8) begin
            d.ish = {q.ish[6:0], 1'b0};
         end
         if (to_hit) begin
            d.ist = I_IDLE;
            d.ibit = '0;
            d.iack = 1'b0;
            d.ifetch = 1'b0;
            d.ird_pend = 1'b0;
            d.icrc = `HSI_CRC_INIT;
            // Only an interrupted transfer reports, so the pulse is one cycle
            d.i2c_to = (q.ist != I_IDLE);
         end
      end
      // Drive low for ACK or a zero bit; held until the falling edge
      d.sda_oe = (d.ibit == 4'd9 && d.iack) ||
         ((d.ist == I_RDAT || d.ist == I_RCRC) && d.ibit <= 4'd8 &&
         !d.ifetch && !d.ird_pend && !d.ish[7]);

      // Four-wire slave: outgoing buffer
      if (spi_tx_load) begin
         d.sout = spi_tx_word;
         d.sout_err = 1'b0;
         d.sfresh = 1'b1;
      end
      if (!q.spi_mode) begin
         d.scnt = '0;
         d.miso = 1'b0;
      end else if (cs_fall) begin
         d.scnt = '0;
         d.sabort = 1'b0;
         d.sstat_ms = '0;
         d.s_crc = cfg_spi_crc;
         d.sfresh = spi_tx_load;
         if (!osc_s) begin
            d.stx = {`HSI_SPI_ALL_ONES, `HSI_SPI_OSC_CRC};
         end else if (!q.sfresh) begin
            d.stx = {`HSI_SPI_ALL_ONES, `HSI_SPI_STALE_CRC};
         end else if (q.sout_err) begin
            d.stx = {q.sout, `HSI_SPI_BAD_CRC};
         end else begin
            d.stx = {q.sout, s_crc_nxt};
         end
         d.miso = d.stx[23];
      end else if (!cs_s) begin
         if (srise && !q.sabort) begin
            d.srx = {q.srx[22:0], mosi_s};
            if (q.scnt != `HSI_SPI_CNT_SAT) begin
               d.scnt = q.scnt + 1'b1;
            end
         end
         if (sfall) begin
            d.stx = {q.stx[22:0], 1'b0};
            d.miso = q.stx[22];
         end
         // Frozen bus: chip select low with no clock edge
         if (srise || sfall) begin
            d.sstat_ms = '0;
         end else if (q.tick && q.sstat_ms != `HSI_MS_SAT) begin
            d.sstat_ms = q.sstat_ms + 1'b1;
         end
         if (q.sstat_ms > `HSI_FROZEN_MS) begin
            d.sabort = 1'b1;
            d.scnt = '0;
            d.sstat_ms = '0;
         end
      end else if (cs_rise && !q.sabort) begin
         d.miso = 1'b0;
         if (q.scnt != (q.s_crc ? `HSI_SPI_LEN_CRC : `HSI_SPI_LEN_PLAIN)) begin
            d.len_err = 1'b1;
         end else if (q.s_crc && q.srx[7:0] != s_crc_nxt) begin
            d.crc_err = 1'b1;
            d.sout = `HSI_SPI_ALL_ONES;
            d.sout_err = 1'b1;
            d.sfresh = 1'b1;
         end else begin
            d.rx_valid = 1'b1;
            d.rx_word = q.s_crc ? q.srx[23:8] : q.srx[15:0];
         end
      end else begin
         d.miso = 1'b0;
      end
      d.miso_oe = d.spi_mode & ~cs_s;

      // Oscillator hold after a chip-select wake
      if (q.spi_mode && cs_fall) begin
         d.hold_ms = hold_ld;
      end else if (q.tick && q.hold_ms != '0) begin
         d.hold_ms = q.hold_ms - 1'b1;
      end
      d.wake = (q.spi_mode & ~cs_s) | (d.hold_ms != '0);
   end

   // State register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         q <= ST_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign sda_o = 1'b0; // Open drain: only the enable moves
   assign sda_oe = q.sda_oe;
   assign spi_miso = q.miso;
   assign spi_miso_oe = q.miso_oe;
   assign osc_wake = q.wake;
   assign reg_acc = q.acc;
   assign spi_rx_valid = q.rx_valid;
   assign spi_rx_word = q.rx_word;
   assign spi_mode = q.spi_mode;
   assign i2c_fast = q.fast;
   assign miso_supply_sel = q.supply;
   assign spi_len_err = q.len_err;
   assign spi_crc_err = q.crc_err;
   assign i2c_timeout = q.i2c_to;
endmodule : hsi_top
`default_nettype wire

// *** sim/hsi_host.sv ***
// Host-side four-wire master model, mode 0
`timescale 1ns/100ps
`default_nettype none
module hsi_host (
   // Host pins
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_mosi,
   // Device reply
   input wire logic spi_miso
);
   // Idle bus: select high, clock low
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
   end

   // Sends n bits MSB first from tx[23]; reply lands in the low bits of rx
   task automatic xfer(input int n, input logic [23:0] tx,
         output logic [23:0] rx);
      rx = '0;
      #50000;
      #1 spi_cs_n = 1'b0;
      #437.5;
      for (int i = 0; i < n; i++) begin
         spi_mosi = tx[23-i];
         #62.5 spi_sclk = 1'b1;
         rx = {rx[22:0], spi_miso};
         #62.5 spi_sclk = 1'b0;
      end
      #200 spi_cs_n = 1'b1;
      // A stale level would hide a missing sample
      spi_mosi = ~spi_mosi;
   endtask : xfer
endmodule : hsi_host
`default_nettype wire

// *** sim/hsi_top_assertions.sv ***
// Port-level checks of the host serial interface
`timescale 1ns/100ps
`default_nettype none
module hsi_top_assertions (
   // Clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // Watched signals
   input wire logic cfg_otp_valid,
   input wire logic config_update_mode,
   input wire logic switch_to_two_wire_cmd,
   input wire logic switch_to_four_wire_cmd,
   input wire logic spi_cs_n,
   input wire logic spi_mode,
   input wire logic i2c_fast,
   input wire logic osc_wake,
   input wire logic spi_miso_oe,
   input wire logic spi_rx_valid,
   input wire logic spi_len_err,
   input wire logic spi_crc_err
);
   default clocking dcb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   AST_MODE_UP: assert property (
      $rose(spi_mode) |-> $past(switch_to_four_wire_cmd) ||
      $past(switch_to_four_wire_cmd, 2) || cfg_otp_valid)
      else $error("four-wire mode entered without a switch");
   AST_MODE_DN: assert property (
      $fell(spi_mode) |-> $past(switch_to_two_wire_cmd) ||
      $past(switch_to_two_wire_cmd, 2) || cfg_otp_valid)
      else $error("two-wire mode entered without a switch");
   AST_FAST_HOLD: assert property (
      config_update_mode && $past(config_update_mode) |-> $stable(i2c_fast))
      else $error("speed changed inside config mode");
   AST_WAKE: assert property (
      $fell(spi_cs_n) && spi_mode |-> ##[1:40] osc_wake)
      else $error("select fall did not wake oscillator");
   AST_OE: assert property (
      spi_miso_oe |-> spi_mode)
      else $error("miso driven outside four-wire mode");
   AST_EXCL: assert property (
      spi_rx_valid |-> !spi_len_err && !spi_crc_err)
      else $error("frame both accepted and flagged");
   AST_RXV: assert property (
      spi_rx_valid |=> !spi_rx_valid)
      else $error("receive strobe longer than one cycle");
   AST_LEN: assert property (
      spi_len_err |-> $past(spi_cs_n, 3))
      else $error("length error before frame end");
endmodule : hsi_top_assertions
bind hsi_top hsi_top_assertions hsi_top_assertions_i (.*);
`default_nettype wire

// *** sim/hsi_top_bench.sv ***
// Self-checking bench of the host serial interface
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module hsi_top_bench import hsi_pkg::*; ;
   logic mclk = 1'b0;
   logic arst_n;
   logic cfg_use_spi = 1'b0;
   logic cfg_otp_valid = 1'b0, cfg_i2c_fast = 1'b1, cfg_i2c_crc = 1'b0;
   logic cfg_spi_crc = 1'b0, cfg_timeout_en = 1'b0;
   logic switch_to_two_wire_cmd = 1'b0;
   logic input_filter_enable_bit = 1'b1, output_supply_select_bit = 1'b0;
   logic [7:0] cfg_idle_time = 8'h00;
   logic miso_supply_sel, spi_crc_err, host_miso;
   logic [23:0] want;
   logic config_update_mode = 1'b0;
   logic switch_to_four_wire_cmd = 1'b0;
   logic osc_ready = 1'b0;
   logic spi_tx_load = 1'b0;
   logic [15:0] spi_tx_word = 16'h0000;
   logic spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe, osc_wake;
   logic spi_rx_valid, spi_mode, i2c_fast, spi_len_err;
   hsi_spi_word_s spi_rx_word;
   logic [23:0] rx;
   int err_total = 0, cmp_count = 0, rx_n = 0, len_n = 0, crc_n = 0, base;

   hsi_top #(.MS_CYCLES(20), .INPUT_FILTER_ENABLE_BIT_CYC(2)) hsi_top_i (.*,
      .cfg_i2c_addr(8'h10), .cfg_i2c_addr_wr(1'b0), .scl_i(1'b1),
      .sda_i(1'b1), .acc_rdata(8'h00), .sda_o(), .sda_oe(), .reg_acc(),
      .i2c_timeout());
   // Undriven MISO shows the inverse, so a sample outside the enable fails
   assign host_miso = spi_miso_oe ? spi_miso : ~spi_miso;
   hsi_host hsi_host_i (.*, .spi_miso(host_miso));

   // 100 MHz clock
   initial begin
      forever #5 mclk = ~mclk;
   end

   // Strobe counters, so one-cycle pulses are never missed
   always @(posedge mclk) begin
      rx_n <= rx_n + spi_rx_valid;
      len_n <= len_n + spi_len_err;
      crc_n <= crc_n + spi_crc_err;
   end

   // Frame checksum: x^8+x^2+x+1 from zero, MSB first
   function automatic logic [7:0] crc16(input logic [15:0] w);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction : crc16

   task automatic frame(input int n, input logic [23:0] tx);
      @(posedge mclk);
      hsi_host_i.xfer(n, tx, rx);
      repeat (20) @(posedge mclk);
   endtask : frame

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   // Main sequence
   initial begin
      // Scheduled, so the reset edge reaches processes already waiting
      arst_n <= 1'b0;
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (6) @(posedge mclk);
      `CHK(spi_mode, 1'b0)
      `CHK(i2c_fast, 1'b1)
      config_update_mode <= 1'b1;
      cfg_use_spi <= 1'b1;
      cfg_i2c_fast <= 1'b0;
      output_supply_select_bit <= 1'b1;
      repeat (4) @(posedge mclk);
      `CHK(i2c_fast, 1'b1)
      config_update_mode <= 1'b0;
      repeat (4) @(posedge mclk);
      `CHK(spi_mode, 1'b0)
      `CHK(i2c_fast, 1'b0)
      `CHK(miso_supply_sel, 1'b0)
      switch_to_four_wire_cmd <= 1'b1;
      @(posedge mclk);
      switch_to_four_wire_cmd <= 1'b0;
      repeat (3) @(posedge mclk);
      `CHK(spi_mode, 1'b1)
      `CHK(miso_supply_sel, 1'b1)
      frame(16, 24'h815500);
      `CHK(rx[15:0], 16'hffff)
      `CHK(osc_wake, 1'b1)
      osc_ready <= 1'b1;
      frame(16, 24'h7e5b00);
      `CHK(rx[15:0], 16'hffff)
      `CHK(spi_rx_word, 16'h7e5b)
      spi_tx_word <= 16'h3ca5;
      spi_tx_load <= 1'b1;
      @(posedge mclk);
      spi_tx_load <= 1'b0;
      frame(16, 24'h012300);
      `CHK(rx[15:0], 16'h3ca5)
      `CHK(spi_rx_word, 16'h0123)
      base = rx_n;
      // Short frame, then a checksum-length frame in plain mode
      for (int n = 8; n <= 24; n += 16) frame(n, 24'h80aa5a);
      `CHK(len_n, 2)
      `CHK(rx_n, base)
      // Checksum frames through the unfiltered input path
      cfg_spi_crc <= 1'b1;
      input_filter_enable_bit <= 1'b0;
      spi_tx_word <= 16'hc3e1;
      spi_tx_load <= 1'b1;
      @(posedge mclk);
      spi_tx_load <= 1'b0;
      frame(24, {16'h0a5c, crc16(16'h0a5c)});
      want = {16'hc3e1, crc16(16'hc3e1)};
      `CHK(rx, want)
      `CHK(spi_rx_word, 16'h0a5c)
      frame(24, {16'h1b6d, ~crc16(16'h1b6d)});
      `CHK(crc_n, 1)
      frame(24, {16'h1b6d, crc16(16'h1b6d)});
      `CHK(rx, 24'hffffaa)
      `CHK(spi_rx_word, 16'h1b6d)
      frame(16, 24'h1b6d00);
      `CHK(rx[15:0], 16'hffff)
      `CHK(len_n, 3)
      `CHK(rx_n, base + 2)
      switch_to_two_wire_cmd <= 1'b1;
      @(posedge mclk);
      switch_to_two_wire_cmd <= 1'b0;
      repeat (3) @(posedge mclk);
      `CHK(spi_mode, 1'b0)
      wrap_up();
   end

   // Hang guard, well past the nine frame gaps
   initial begin
      #700000;
      err_total++;
      wrap_up();
   end
endmodule : hsi_top_bench
`default_nettype wire
